// ===== shared/two_wire_pkg.sv
// constants, field layouts and state types of the two-wire slave receiver
// assumes a 200 MHz system clock and a 32-bit avalon-mm register port
package two_wire_pkg;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [4:0] OFS_OWN_ADDR = 5'h00;
    localparam logic [4:0] OFS_CONTROL = 5'h04;
    localparam logic [4:0] OFS_STATUS = 5'h08;
    localparam logic [4:0] OFS_DATA = 5'h0c;
    localparam logic [4:0] OFS_EVT_STATUS = 5'h10;
    localparam logic [4:0] OFS_EVT_MASK = 5'h14;
    localparam logic [4:0] OFS_POWER = 5'h18;

    // ****************************************
    // serial_control bit positions
    // ****************************************
    localparam int CTL_IRQ_FLAG = 7;
    localparam int CTL_ACK_ENABLE = 6;
    localparam int CTL_START_REQ = 5;
    localparam int CTL_STOP_REQ = 4;
    localparam int CTL_WCOL = 3;
    localparam int CTL_IFACE_EN = 2;
    localparam int CTL_IRQ_EN = 0;

    // ****************************************
    // event bits, reset values, bus constants
    // ****************************************
    localparam int EVT_ADDRESSED = 0;
    localparam int EVT_BYTE_RX = 1;
    localparam int EVT_STOP = 2;
    localparam int EVT_W = 3;
    localparam int PWR_DEEP_SLEEP = 0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] STATUS_IDLE = 8'hf8;
    localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ****************************************
    // status codes, prescaler bits zero
    // ****************************************
    localparam logic [7:0] ST_OWN_W_ACK = 8'h60;
    localparam logic [7:0] ST_ARB_OWN_W_ACK = 8'h68;
    localparam logic [7:0] ST_GC_ACK = 8'h70;
    localparam logic [7:0] ST_ARB_GC_ACK = 8'h78;
    localparam logic [7:0] ST_DATA_ACK = 8'h80;
    localparam logic [7:0] ST_DATA_NACK = 8'h88;
    localparam logic [7:0] ST_GC_DATA_ACK = 8'h90;
    localparam logic [7:0] ST_GC_DATA_NACK = 8'h98;

    typedef enum logic [3:0] {
        SL_IDLE, SL_ADDR, SL_ADDR_ACK_PREP, SL_ADDR_ACK,
        SL_DATA, SL_DATA_ACK_PREP, SL_DATA_ACK, SL_HOLD, SL_IGNORE
    } slave_state_e;

endpackage

// ===== shared/bus_events_if.sv
// bus line events passed from the line synchroniser to its consumers
// assumes every signal is a one-cycle pulse on sys_clk except sda_level
`timescale 1ns/100ps
interface bus_events_if;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic sda_level;

    modport src (output scl_rise, output scl_fall, output start_seen,
        output stop_seen, output sda_level);
    modport sink (input scl_rise, input scl_fall, input start_seen,
        input stop_seen, input sda_level);
endinterface

// ===== logic/line_sync.sv
// two-flop synchroniser of scl and sda with edge, start and stop detection
// assumes the bus lines are asynchronous to sys_clk and far slower
`timescale 1ns/100ps
module line_sync (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    // decoded events
    bus_events_if.src ev
);
    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic sda_s1;
        logic sda_s2;
        logic scl_d;
        logic sda_d;
    } sync_s;

    sync_s sync_reg;
    sync_s sync_next;

    always_comb begin
        sync_next = sync_reg;
        sync_next.scl_s1 = scl_in;
        sync_next.scl_s2 = sync_reg.scl_s1;
        sync_next.sda_s1 = sda_in;
        sync_next.sda_s2 = sync_reg.sda_s1;
        sync_next.scl_d = sync_reg.scl_s2;
        sync_next.sda_d = sync_reg.sda_s2;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            // idle bus is high on both lines
            sync_reg <= '1;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign ev.scl_rise = sync_reg.scl_s2 & ~sync_reg.scl_d;
    assign ev.scl_fall = ~sync_reg.scl_s2 & sync_reg.scl_d;
    assign ev.start_seen = sync_reg.scl_s2 & sync_reg.scl_d & sync_reg.sda_d & ~sync_reg.sda_s2;
    assign ev.stop_seen = sync_reg.scl_s2 & sync_reg.scl_d & ~sync_reg.sda_d & sync_reg.sda_s2;
    assign ev.sda_level = sync_reg.sda_s2;
endmodule

// ===== logic/byte_shifter.sv
// collects eight sda bits per byte on scl rising edges, skips the ack bit
// assumes events from line_sync; a start realigns the bit count
`timescale 1ns/100ps
module byte_shifter (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // bus events
    bus_events_if.sink ev,
    // received byte
    output logic [7:0] byte_val,
    output logic byte_done
);
    import two_wire_pkg::*;

    typedef struct packed {
        logic [7:0] shift;
        logic [3:0] cnt;
        logic done;
    } shift_s;

    shift_s sh_reg;
    shift_s sh_next;

    always_comb begin
        sh_next = sh_reg;
        sh_next.done = 1'b0;
        if (ev.start_seen) begin
            sh_next.cnt = 4'h0;
        end else if (ev.scl_rise) begin
            if (sh_reg.cnt == BITS_PER_BYTE) begin
                // ninth clock carries the ack, not data
                sh_next.cnt = 4'h0;
            end else begin
                sh_next.shift = {sh_reg.shift[6:0], ev.sda_level};
                sh_next.cnt = sh_reg.cnt + 4'h1;
                sh_next.done = (sh_reg.cnt == BITS_PER_BYTE - 4'h1);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sh_reg <= '0;
        end else begin
            sh_reg <= sh_next;
        end
    end

    assign byte_val = sh_reg.shift;
    assign byte_done = sh_reg.done;
endmodule

// ===== logic/two_wire_slave_receiver.sv
// slave receiver of a byte-oriented two-wire serial interface, avalon-mm registers
// assumes open-drain scl/sda pads outside and a 200 MHz sys_clk
//
// What this block does
// [R1] answers the address held in the upper seven own-address bits
// [R2] own-address bit zero enables answering the general call address
// [R3] software enables the interface and writes the flag bit as zero
// [R4] address acknowledged only while ack_enable is one
// [R5] software writes start and stop request as zero for reception
// [R6] write direction enters slave receive, read direction slave transmit; here read direction only sets st_mode and waits in SL_IGNORE
// [R7] own address with write received sets flag and valid status
// [R8] addressed after lost arbitration reports 0x68 or 0x78
// [R9] ack_enable cleared mid-transfer gives nack after next data byte
// [R10] with ack_enable zero, keep watching bus, resume when set
// [R11] deep sleep still recognises and acknowledges address from bus clock
// [R12] after waking match, scl held low until flag cleared by one
// [R13] data register not updated while asleep; contents unreliable
// [R14] after 0x60 clear flag, next byte acked per ack_enable
// [R15] after 0x68 clear flag, next byte acked per ack_enable
// [R16] after 0x70 clear flag, next byte acked per ack_enable
// [R17] status compared with prescaler bits zero
// [R18] writing one to flag clears it and continues; zero leaves it
// [R19] interrupt raised while flag set and irq_enable is one
//
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
module two_wire_slave_receiver (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // avalon-mm register slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // open-drain bus pins
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // master side, same clock
    input wire logic master_arb_lost,
    // system
    output logic irq,
    output logic wake_req
);
    import two_wire_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        slave_state_e state;
        logic [7:0] own_addr;
        logic irq_flag;
        logic ack_enable;
        logic start_req;
        logic stop_req;
        logic wcol;
        logic iface_en;
        logic irq_en;
        logic [7:0] status;
        logic [7:0] data;
        logic deep_sleep;
        logic [EVT_W-1:0] evt;
        logic [EVT_W-1:0] evt_mask;
        logic gc_active;
        logic nack_pending;
        logic st_mode;
        logic served;
        logic [31:0] rdata;
    } top_s;

    top_s r_reg;
    top_s r_next;

    bus_events_if ev ();
    logic [7:0] rx_byte;
    logic rx_done;

    line_sync u_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .ev(ev)
    );

    byte_shifter u_shift (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .ev(ev),
        .byte_val(rx_byte),
        .byte_done(rx_done)
    );

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
        hit = (addr == ofs);
    endfunction

    function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] wd,
        input logic [3:0] be);
        lane0 = be[0] ? wd[7:0] : old;
    endfunction

    logic req;
    logic acc_wr;
    logic acc_rd;
    logic [7:0] ctl_view;
    logic [7:0] wr_byte;
    logic own_hit;
    logic gc_hit;
    logic flag_set;
    logic flag_clr;
    logic [EVT_W-1:0] evt_set;

    assign req = avs_read | avs_write;
    // request taken on the second cycle, once read data is registered
    assign acc_wr = avs_write & r_reg.served;
    assign acc_rd = avs_read & r_reg.served;
    assign wr_byte = avs_writedata[7:0];

    always_comb begin
        ctl_view = RST_BYTE;
        ctl_view[CTL_IRQ_FLAG] = r_reg.irq_flag;
        ctl_view[CTL_ACK_ENABLE] = r_reg.ack_enable;
        ctl_view[CTL_START_REQ] = r_reg.start_req;
        ctl_view[CTL_STOP_REQ] = r_reg.stop_req;
        ctl_view[CTL_WCOL] = r_reg.wcol;
        ctl_view[CTL_IFACE_EN] = r_reg.iface_en;
        ctl_view[CTL_IRQ_EN] = r_reg.irq_en;
    end

    // address compare against the received byte
    assign own_hit = (rx_byte[7:1] == r_reg.own_addr[7:1]); // R1
    assign gc_hit = (rx_byte[7:1] == GENERAL_CALL_ADDR) & r_reg.own_addr[0]; // R2

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        r_next = r_reg;
        flag_set = 1'b0;
        evt_set = '0;

        // avalon handshake: one wait cycle, data registered in it
        r_next.served = req & ~r_reg.served;
        if (req & ~r_reg.served) begin
            r_next.rdata = '0;
            if (hit(avs_address, OFS_OWN_ADDR)) begin
                r_next.rdata[7:0] = r_reg.own_addr;
            end else if (hit(avs_address, OFS_CONTROL)) begin
                r_next.rdata[7:0] = ctl_view;
            end else if (hit(avs_address, OFS_STATUS)) begin
                // prescaler bits [1:0] always read zero
                r_next.rdata[7:0] = r_reg.status; // R17
            end else if (hit(avs_address, OFS_DATA)) begin
                r_next.rdata[7:0] = r_reg.data;
            end else if (hit(avs_address, OFS_EVT_STATUS)) begin
                r_next.rdata[EVT_W-1:0] = r_reg.evt;
            end else if (hit(avs_address, OFS_EVT_MASK)) begin
                r_next.rdata[EVT_W-1:0] = r_reg.evt_mask;
            end else if (hit(avs_address, OFS_POWER)) begin
                r_next.rdata[PWR_DEEP_SLEEP] = r_reg.deep_sleep;
            end
        end

        // ****************************************
        // slave sequencer
        // ****************************************
        if (!r_reg.iface_en) begin
            r_next.state = SL_IDLE;
            r_next.nack_pending = 1'b0;
        end else if (ev.stop_seen) begin
            r_next.state = SL_IDLE;
            evt_set[EVT_STOP] = 1'b1;
        end else if (ev.start_seen) begin
            // every start re-arms recognition, so ack_enable may return anytime
            r_next.state = SL_ADDR; // R10
            r_next.st_mode = 1'b0;
        end else begin
            case (r_reg.state)
                SL_ADDR: begin
                    if (rx_done) begin
                        if (r_reg.ack_enable && own_hit && !rx_byte[0]) begin // R4 R6
                            r_next.gc_active = 1'b0;
                            r_next.status = master_arb_lost ? ST_ARB_OWN_W_ACK
                                : ST_OWN_W_ACK; // R8
                            r_next.state = SL_ADDR_ACK_PREP;
                        end else if (r_reg.ack_enable && gc_hit) begin // R2 R4
                            r_next.gc_active = 1'b1;
                            r_next.status = master_arb_lost ? ST_ARB_GC_ACK
                                : ST_GC_ACK; // R8
                            r_next.state = SL_ADDR_ACK_PREP;
                        end else begin
                            // read direction only sets st_mode, then the sequencer waits in SL_IGNORE
                            r_next.st_mode = r_reg.ack_enable & own_hit & rx_byte[0]; // R6
                            r_next.state = SL_IGNORE; // R10
                        end
                    end
                end
                SL_ADDR_ACK_PREP: begin
                    if (ev.scl_fall) begin
                        r_next.state = SL_ADDR_ACK;
                    end
                end
                SL_ADDR_ACK: begin
                    if (ev.scl_fall) begin
                        flag_set = 1'b1; // R7
                        evt_set[EVT_ADDRESSED] = 1'b1;
                        r_next.nack_pending = 1'b0;
                        r_next.state = SL_HOLD;
                    end
                end
                SL_DATA: begin
                    if (rx_done) begin
                        // bus clock alone runs while asleep; keep old byte
                        if (!r_reg.deep_sleep) begin
                            r_next.data = rx_byte; // R13
                        end
                        r_next.nack_pending = ~r_reg.ack_enable; // R9 R14 R15 R16
                        if (r_reg.gc_active) begin
                            r_next.status = r_reg.ack_enable ? ST_GC_DATA_ACK
                                : ST_GC_DATA_NACK;
                        end else begin
                            r_next.status = r_reg.ack_enable ? ST_DATA_ACK
                                : ST_DATA_NACK;
                        end
                        r_next.state = SL_DATA_ACK_PREP;
                    end
                end
                SL_DATA_ACK_PREP: begin
                    if (ev.scl_fall) begin
                        r_next.state = SL_DATA_ACK;
                    end
                end
                SL_DATA_ACK: begin
                    if (ev.scl_fall) begin
                        flag_set = 1'b1;
                        evt_set[EVT_BYTE_RX] = 1'b1;
                        r_next.state = SL_HOLD;
                    end
                end
                SL_HOLD: begin
                    // scl stays low until software releases the flag
                    if (!r_reg.irq_flag) begin
                        r_next.state = r_reg.nack_pending ? SL_IGNORE : SL_DATA; // R14 R15 R16
                    end
                end
                SL_IDLE, SL_IGNORE: begin
                    r_next.state = r_reg.state;
                end
                default: begin
                    r_next.state = SL_IDLE;
                end
            endcase
        end

        // ****************************************
        // register writes
        // ****************************************
        flag_clr = 1'b0;
        if (acc_wr && avs_byteenable[0]) begin
            if (hit(avs_address, OFS_OWN_ADDR)) begin
                r_next.own_addr = lane0(r_reg.own_addr, avs_writedata, avs_byteenable);
            end else if (hit(avs_address, OFS_CONTROL)) begin
                flag_clr = wr_byte[CTL_IRQ_FLAG]; // R18
                r_next.ack_enable = wr_byte[CTL_ACK_ENABLE]; // R9
                r_next.start_req = wr_byte[CTL_START_REQ]; // R5
                r_next.stop_req = wr_byte[CTL_STOP_REQ]; // R5
                r_next.iface_en = wr_byte[CTL_IFACE_EN]; // R3
                r_next.irq_en = wr_byte[CTL_IRQ_EN];
            end else if (hit(avs_address, OFS_DATA)) begin
                // data is only writable while the flag holds the bus
                if (r_reg.irq_flag) begin
                    r_next.data = wr_byte;
                    r_next.wcol = 1'b0;
                end else begin
                    r_next.wcol = 1'b1;
                end
            end else if (hit(avs_address, OFS_EVT_MASK)) begin
                r_next.evt_mask = wr_byte[EVT_W-1:0];
            end else if (hit(avs_address, OFS_POWER)) begin
                r_next.deep_sleep = wr_byte[PWR_DEEP_SLEEP];
            end
        end

        // hardware set wins over a clear in the same cycle
        r_next.irq_flag = flag_set | (r_reg.irq_flag & ~flag_clr); // R18
        if (acc_rd && hit(avs_address, OFS_EVT_STATUS)) begin
            // clear only what the read returned; a later event survives
            r_next.evt = evt_set | (r_reg.evt & ~r_reg.rdata[EVT_W-1:0]);
        end else begin
            r_next.evt = r_reg.evt | evt_set;
        end
        if (!r_next.iface_en) begin
            r_next.irq_flag = 1'b0;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            r_reg <= '0;
            r_reg.state <= SL_IDLE;
            r_reg.status <= STATUS_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign avs_waitrequest = req & ~r_reg.served;
    assign avs_readdata = r_reg.rdata;

    // open drain: only ever pull low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    // stretch covers a wake from deep sleep; long start-up blocks the bus
    assign scl_oe = (r_reg.state == SL_HOLD) & r_reg.irq_flag; // R12
    // deep sleep takes the same path, so matches still get acked
    assign sda_oe = (r_reg.state == SL_ADDR_ACK) // R11
        | ((r_reg.state == SL_DATA_ACK) & ~r_reg.nack_pending); // R9

    assign irq = (r_reg.irq_flag & r_reg.irq_en) | (|(r_reg.evt & r_reg.evt_mask)); // R19
    assign wake_req = r_reg.deep_sleep & r_reg.irq_flag; // R12
endmodule

// ===== verification/two_wire_assertions.sv
// port checker of the two-wire slave receiver, bound to its top module
// assumes the top module's ports only, one clock domain
`timescale 1ns/100ps
module two_wire_assertions (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // register bus
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // bus pins and system
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic wake_req
);
    import two_wire_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    wire logic rd_done = avs_read && !avs_waitrequest;

    AST_WAIT_READ: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read not answered in its second cycle");
    AST_WAIT_WRITE: assert property ($rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("write not answered in its second cycle");
    AST_STATUS_LOW: assert property (rd_done && avs_address == OFS_STATUS |->
        avs_readdata[2:0] == 3'h0) else $error("status low bits not zero");
    AST_UPPER_ZERO: assert property (rd_done |-> avs_readdata[31:8] == 24'h0)
        else $error("read data above bit 7 not zero");
    AST_OPEN_DRAIN: assert property (!scl_out && !sda_out)
        else $error("pin driven high instead of released");
    AST_ACK_LEN: assert property ($rose(sda_oe) |-> sda_oe[*8] ##[1:12] !sda_oe)
        else $error("ack pull of wrong length");
    AST_ACK_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("sda pull changed while scl high");
    AST_STRETCH: assert property ($fell(sda_oe) |-> ##[0:4] scl_oe)
        else $error("no clock hold after ack");
    AST_WAKE_HOLD: assert property ($fell(scl_oe) |-> !wake_req)
        else $error("scl released while wake pending");

    cover property ($rose(sda_oe));
    cover property ($rose(wake_req));
    cover property (rd_done && avs_address == OFS_STATUS);
endmodule

bind two_wire_slave_receiver two_wire_assertions chk (.sys_clk, .reset_n, .avs_address,
    .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .scl_in, .scl_out, .scl_oe,
    .sda_out, .sda_oe, .wake_req);

// ===== verification/wire_master_model.sv
// external master transmitter on the open-drain clock and data lines
// assumes pull-ups on both lines and an 80 ns bus clock period
`timescale 1ns/100ps
module wire_master_model (
    // pulls by the slave
    input wire logic scl_oe,
    input wire logic sda_oe,
    // resolved line levels
    output logic scl,
    output logic sda
);
    logic scl_low = 1'b0;
    logic sda_low = 1'b0;
    // pull-ups: a released line reads high
    assign scl = !(scl_low || scl_oe);
    assign sda = !(sda_low || sda_oe);

    // sda moves 20 ns after scl falls, so no false start or stop is seen
    task automatic pulse(input logic b, output logic s);
        sda_low = !b;
        #20;
        scl_low = 1'b0;
        wait (scl === 1'b1);
        #40;
        s = sda;
        scl_low = 1'b1;
        #20;
    endtask
    task automatic start;
        #13;
        sda_low = 1'b1;
        #40;
        scl_low = 1'b1;
        #20;
    endtask
    task automatic stop;
        sda_low = 1'b1;
        #20;
        scl_low = 1'b0;
        wait (scl === 1'b1);
        #40;
        sda_low = 1'b0;
        #80;
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            pulse(d[i], s);
        end
        pulse(1'b1, s);
        ack = !s;
        #40;
    endtask
endmodule

// ===== verification/tb.sv
// self-checking bench of the two-wire slave receiver
// assumes the master model on the pins and avalon-mm register access
`timescale 1ns/100ps
module tb;
    import two_wire_pkg::*;
    logic sys_clk, reset_n, avs_read, avs_write, master_arb_lost;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic avs_waitrequest, scl_oe, sda_oe, irq, wake_req;
    wire logic scl_line, sda_line;
    int miscompares = 0;
    int n_compared = 0;

    two_wire_slave_receiver DUT (.sys_clk, .reset_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .scl_in(scl_line), .scl_out(), .scl_oe, .sda_in(sda_line), .sda_out(), .sda_oe,
        .master_arb_lost, .irq, .wake_req);
    wire_master_model master (.scl_oe, .sda_oe, .scl(scl_line), .sda(sda_line));

    always #2.5 sys_clk = ~sys_clk;

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic report_and_stop;
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // request held to the edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
            output logic [7:0] q);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic expect_reg(input logic [4:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask
    // one byte on the wire; a nonzero status means the clock must be held
    task automatic xfer(input logic [7:0] d, input logic e_ack, input logic [7:0] e_st);
        logic a;
        logic [7:0] q;
        master.send_byte(d, a);
        chk({7'h0, a}, {7'h0, e_ack});
        if (e_st != 8'h00) begin
            bus(1'b0, OFS_STATUS, 8'h00, q);
            chk(q & 8'hf8, e_st);
            chk({7'h0, scl_oe}, 8'h01);
        end
    endtask
    task automatic finish_xfer;
        wr(OFS_CONTROL, 8'hc5);
        master.stop();
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic s_regs;
        expect_reg(OFS_STATUS, STATUS_IDLE);
        expect_reg(OFS_OWN_ADDR, RST_BYTE);
        wr(5'h1c, 8'h5a);
        expect_reg(5'h1c, 8'h00);
        wr(OFS_OWN_ADDR, 8'hb4);
        expect_reg(OFS_OWN_ADDR, 8'hb4);
    endtask
    task automatic s_own_write;
        wr(OFS_CONTROL, 8'h45);
        master.start();
        xfer(8'hb4, 1'b1, ST_OWN_W_ACK);
        expect_reg(OFS_CONTROL, 8'hc5);
        chk({7'h0, irq}, 8'h01);
        expect_reg(OFS_EVT_STATUS, 8'h01);
        expect_reg(OFS_EVT_STATUS, 8'h00);
        wr(OFS_CONTROL, 8'h45);
        expect_reg(OFS_CONTROL, 8'hc5);
        wr(OFS_CONTROL, 8'hc5);
        xfer(8'h3c, 1'b1, ST_DATA_ACK);
        expect_reg(OFS_DATA, 8'h3c);
        wr(OFS_CONTROL, 8'h85);
        xfer(8'h99, 1'b0, ST_DATA_NACK);
        finish_xfer();
    endtask
    task automatic s_general_call;
        master.start();
        xfer(8'h00, 1'b0, 8'h00);
        master.stop();
        wr(OFS_OWN_ADDR, 8'hb5);
        master.start();
        xfer(8'h00, 1'b1, ST_GC_ACK);
        wr(OFS_CONTROL, 8'hc5);
        xfer(8'h11, 1'b1, ST_GC_DATA_ACK);
        finish_xfer();
    endtask
    task automatic s_ack_off;
        wr(OFS_CONTROL, 8'h05);
        master.start();
        xfer(8'hb4, 1'b0, 8'h00);
        master.stop();
        wr(OFS_CONTROL, 8'h45);
        master.start();
        xfer(8'hb4, 1'b1, ST_OWN_W_ACK);
        finish_xfer();
        master.start();
        xfer(8'hb5, 1'b0, 8'h00);
        master.stop();
    endtask
    task automatic s_arb_lost;
        @(posedge sys_clk);
        master_arb_lost <= 1'b1;
        master.start();
        xfer(8'h00, 1'b1, ST_ARB_GC_ACK);
        finish_xfer();
        master.start();
        xfer(8'hb4, 1'b1, ST_ARB_OWN_W_ACK);
        master_arb_lost <= 1'b0;
        wr(OFS_CONTROL, 8'h85);
        xfer(8'h42, 1'b0, ST_DATA_NACK);
        finish_xfer();
    endtask
    task automatic s_sleep;
        wr(OFS_CONTROL, 8'h45);
        wr(OFS_POWER, 8'h01);
        master.start();
        xfer(8'hb4, 1'b1, ST_OWN_W_ACK);
        chk({7'h0, wake_req}, 8'h01);
        wr(OFS_CONTROL, 8'hc5);
        repeat (3) @(posedge sys_clk);
        chk({6'h0, wake_req, scl_oe}, 8'h00);
        xfer(8'h5e, 1'b1, ST_DATA_ACK);
        expect_reg(OFS_DATA, 8'h42);
        wr(OFS_POWER, 8'h00);
        finish_xfer();
    endtask

    initial begin
        #200000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        sys_clk = 1'b0;
        reset_n = 1'b0;
        {avs_read, avs_write, master_arb_lost} = 3'h0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        s_regs();
        s_own_write();
        s_general_call();
        s_ack_off();
        s_arb_lost();
        s_sleep();
        report_and_stop();
    end
endmodule
